// [design/teletext_acq_pkg.sv]
// Constants, types and register map for the teletext acquisition store
// Assumes one core clock; all users import this package.
//
// Notes on behaviour
// - Acquisition buffer is a FIFO with separate write and read pointers.
// - The FIFO holds three bytes.
// - Write-allowed goes high whenever pointers show at least one byte stored.
// - Empty FIFO drops write-allowed; the RAM side then does a read cycle.
// - Storage address toward the RAM side is 14 bits wide.
// - Software loads the address pointer through a high and a low register.
// - Pointer post-increments after each byte stored; it names the next free byte.
// - A backup register holds the address of the current line's first byte.
// - Early line sync reloads the backup address and empties the FIFO.
// - A line longer than 41 bytes keeps only its first 41.
// - After a truncated line, storing resumes only at a valid framing code.
// - A standalone decoder checks Hamming 24/18 groups and 8/4 bytes.
// - After the last 24/18 byte, an 18-bit result and validity bit appear.
// - After an 8/4 byte, a 4-bit result and validity bit appear.
// - Invalid-code flag reads at bit 23 for 24/18, bit 4 for 8/4.
// - The 24-bit word has the fixed protection, data and address bit layout.
// - Six checks are XORs over fixed bit sets of the word.
// - A single-bit error is corrected by complementing the bit at its position.
// - Error position above 23 rejects the group and sets the flag; position zero means no error.

`default_nettype none

package teletext_acq_pkg;

  localparam int              FIFO_DEPTH = 3;
  localparam int              ADDR_W     = 14;
  localparam logic [5:0]      LINE_BYTES = 6'h29;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;

  // Register offsets
  localparam logic [3:0] OFF_ADDR_LOW  = 4'h0;
  localparam logic [3:0] OFF_ADDR_HIGH = 4'h1;
  localparam logic [3:0] OFF_HAM_LOW   = 4'h2;
  localparam logic [3:0] OFF_HAM_MID   = 4'h3;
  localparam logic [3:0] OFF_HAM_HIGH  = 4'h4;
  localparam logic [3:0] OFF_STATUS    = 4'h5;

  // Status fields
  localparam int ST_COUNT_LSB = 0;
  localparam int ST_OVERRUN   = 2;
  localparam int ST_LINE_LSB  = 3;
  localparam int ST_HAM_WIDE  = 5;

  // Check masks over the 24-bit word, index 0 is the first check
  localparam logic [5:0][23:0] CHK24_MASK = {
    24'hffffff, 24'h7f8000, 24'h007f80,
    24'h786878, 24'h666666, 24'h555555};
  // 8/4 checks, index 0 is the first equation
  localparam logic [3:0][7:0] CHK8_MASK = {8'hff, 8'h3a, 8'h8e, 8'ha3};
  localparam logic [4:0] POS_MAX = 5'h17;

  typedef enum logic [1:0] {
    LN_IDLE  = 2'b00,
    LN_STORE = 2'b01,
    LN_DONE  = 2'b11
  } lineState_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } regReq_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } filtByte_t;

  typedef struct packed {
    logic              writeAllowed;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } ramReq_t;

  typedef logic [2:0] fifoPtr_t;

endpackage

`default_nettype wire

// [design/hamming_decoder.sv]
// Combinational Hamming 24/18 and 8/4 checker and corrector
// Assumes the caller registers the results.

`default_nettype none

module hamming_decoder
  import teletext_acq_pkg::*;
(
  input  wire logic [23:0] codeWord,
  output logic      [23:0] result24,
  output logic      [7:0]  result8
);

  logic [5:0]  chk;
  logic [3:0]  chk8;
  logic [4:0]  pos;
  logic [23:0] fix;
  logic        err;
  logic [7:0]  fix8;
  logic        err8;
  logic [2:0]  abc;

  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_chk
      assign chk[i] = ^(codeWord & CHK24_MASK[i]);
    end
    for (i = 0; i < 4; i++)
    begin : g_chk8
      assign chk8[i] = ^(codeWord[7:0] & CHK8_MASK[i]);
    end
  endgenerate

  // Passing checks read 1, so the position is the inverted checks
  assign pos = ~chk[4:0];

  always_comb
  begin
    fix = codeWord;
    err = 1'b0;
    if (pos != 5'h00)
    begin
      if (chk[5])
        err = 1'b1;
      else if (pos > POS_MAX)
        err = 1'b1;
      else
        fix[5'(pos - 5'h01)] = ~codeWord[5'(pos - 5'h01)];
    end
    // Data bits only; protection bits are dropped
    result24 = {err, 5'h00, fix[22:16], fix[14:8], fix[6:4], fix[2]};
  end

  assign abc = {chk8[0], chk8[1], chk8[2]};

  always_comb
  begin
    fix8 = codeWord[7:0];
    err8 = 1'b0;
    if (chk8[3])
      err8 = (abc != 3'h7);
    else
    begin
      case (abc)
        3'h0:    fix8[1] = ~codeWord[1];
        3'h1:    fix8[7] = ~codeWord[7];
        3'h2:    fix8[5] = ~codeWord[5];
        3'h4:    fix8[3] = ~codeWord[3];
        default: fix8 = codeWord[7:0];
      endcase
    end
    result8 = {3'h0, err8, fix8[7], fix8[5], fix8[3], fix8[1]};
  end

endmodule

`default_nettype wire

// [design/teletext_acq_store.sv]
// Acquisition buffer, storage address generation and Hamming decoder
// Assumes filter, sync and RAM side signals are on clk_sys.
//
// Chosen here: the strobed register port and the register offsets.

`default_nettype none

module teletext_acq_store
  import teletext_acq_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        clkEn,
  input  wire teletext_acq_pkg::regReq_t   regReq,
  output logic      [7:0]                  regRdata,
  input  wire teletext_acq_pkg::filtByte_t filtIn,
  input  wire logic                        framingOk,
  input  wire logic                        lineSync,
  input  wire logic                        vbiActive,
  input  wire logic                        ramSlot,
  output teletext_acq_pkg::ramReq_t        ramReq
);

  import teletext_acq_pkg::*;

  logic [7:0]        fifoMem_r [FIFO_DEPTH];
  fifoPtr_t          wrPtr_r;
  fifoPtr_t          rdPtr_r;
  logic              fifoEmpty;
  logic              fifoFull;
  logic [1:0]        fifoCount;
  logic              accept;
  logic              push;
  logic              pop;
  logic              abort;

  // Address side
  logic [ADDR_W-1:0] addrPtr_r;
  logic [ADDR_W-1:0] backup_r;
  lineState_t        lineState_r;
  logic [5:0]        lineCnt_r;
  logic              overrun_r;

  // Decoder side
  logic [23:0]       hamIn_r;
  logic              hiSeen_r;
  logic              midSeen_r;
  logic              hamWide_r;
  logic [23:0]       hamRes_r;
  logic [23:0]       decIn;
  logic [23:0]       dec24;
  logic [7:0]        dec8;
  logic [7:0]        regRdata_r;
  logic              wrAddrLo;
  logic              wrAddrHi;
  logic              wrHamLo;
  logic              wrHamMid;
  logic              wrHamHi;
  logic              wrStatus;

  // Pointer step with wrap bit
  // Index runs 0 to 2; the top bit flips at each wrap
  function automatic fifoPtr_t ptrNext(input fifoPtr_t p);
    if (p[1:0] == 2'(FIFO_DEPTH - 1))
      ptrNext = {~p[2], 2'h0};
    else
      ptrNext = {p[2], 2'(p[1:0] + 2'h1)};
  endfunction

  // Register decode
  // Unmapped writes match nothing and are ignored
  assign wrAddrLo = regReq.wr && (regReq.addr == OFF_ADDR_LOW);
  assign wrAddrHi = regReq.wr && (regReq.addr == OFF_ADDR_HIGH);
  assign wrHamLo  = regReq.wr && (regReq.addr == OFF_HAM_LOW);
  assign wrHamMid = regReq.wr && (regReq.addr == OFF_HAM_MID);
  assign wrHamHi  = regReq.wr && (regReq.addr == OFF_HAM_HIGH);
  assign wrStatus = regReq.wr && (regReq.addr == OFF_STATUS);

  // Pointer comparison; the wrap bit tells full from empty
  assign fifoEmpty = (wrPtr_r == rdPtr_r);
  assign fifoFull  = (wrPtr_r[1:0] == rdPtr_r[1:0]) && (wrPtr_r[2] != rdPtr_r[2]);

  // Byte count for status and backup
  always_comb
  begin
    if (fifoEmpty)
      fifoCount = 2'h0;
    else if (wrPtr_r[2] == rdPtr_r[2])
      fifoCount = 2'(wrPtr_r[1:0] - rdPtr_r[1:0]);
    else
      fifoCount = 2'(2'(FIFO_DEPTH) + wrPtr_r[1:0] - rdPtr_r[1:0]);
  end

  // Bytes are taken only inside an open line; framing and sync cycles take none
  assign accept = (lineState_r == LN_STORE) && filtIn.valid && vbiActive
                  && !lineSync && !framingOk;
  assign push   = accept && !fifoFull;

  // Short line: sync while the line still lacks bytes
  // Done or idle lines are already closed, so sync there is harmless
  assign abort  = lineSync && (lineState_r == LN_STORE) && (lineCnt_r != 6'h00);

  // Abort wins over a RAM slot in the same cycle
  assign pop    = ramSlot && !fifoEmpty && !abort;

  // FIFO pointers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wrPtr_r <= 3'h0;
      rdPtr_r <= 3'h0;
    end
    else if (clkEn)
    begin
      if (abort)
      begin
        wrPtr_r <= 3'h0;
        rdPtr_r <= 3'h0;
      end
      else
      begin
        if (push)
          wrPtr_r <= ptrNext(wrPtr_r);
        if (pop)
          rdPtr_r <= ptrNext(rdPtr_r);
      end
    end
  end

  // FIFO storage, three entries
  // No reset; empty pointers hide stale entries
  always_ff @(posedge clk_sys)
  begin
    if (clkEn && push)
      fifoMem_r[wrPtr_r[1:0]] <= filtIn.data;
  end

  // Sticky overrun when a byte meets a full buffer
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      overrun_r <= 1'b0;
    else if (clkEn)
    begin
      if (accept && fifoFull)
        overrun_r <= 1'b1;
      else if (wrStatus && regReq.wdata[ST_OVERRUN])
        overrun_r <= 1'b0;
    end
  end

  // Storage address pointer
  // Abort first, then software, then the RAM side
  // Software writes in blanking can race a pop; not guarded
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      addrPtr_r <= ADDR_RST;
    else if (clkEn)
    begin
      if (abort)
        addrPtr_r <= backup_r;
      else if (wrAddrHi)
        addrPtr_r[ADDR_W-1:8] <= regReq.wdata[ADDR_W-9:0];
      else if (wrAddrLo)
        addrPtr_r[7:0] <= regReq.wdata;
      else if (pop)
        addrPtr_r <= 14'(addrPtr_r + 14'h0001);
    end
  end

  // Bytes still queued precede the new line, so skip past them
  // A pop in the same cycle leaves the sum unchanged
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      backup_r <= ADDR_RST;
    else if (clkEn && framingOk)
      backup_r <= 14'(addrPtr_r + {12'h000, fifoCount});
  end

  // Line tracking and truncation
  // Count runs to 41 and then parks in done
  // Sync closes any line; framing always reopens
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      lineState_r <= LN_IDLE;
      lineCnt_r   <= 6'h00;
    end
    else if (clkEn)
    begin
      if (framingOk)
      begin
        lineState_r <= LN_STORE;
        lineCnt_r   <= 6'h00;
      end
      else if (lineSync)
      begin
        lineState_r <= LN_IDLE;
        lineCnt_r   <= 6'h00;
      end
      else if (accept)
      begin
        lineCnt_r <= 6'(lineCnt_r + 6'h01);
        if (lineCnt_r == 6'(LINE_BYTES - 6'h01))
          lineState_r <= LN_DONE;
      end
    end
  end

  // Hamming input bytes, high and mid first, low last
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      hamIn_r   <= 24'h000000;
      hiSeen_r  <= 1'b0;
      midSeen_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (wrHamHi)
      begin
        hamIn_r[23:16] <= regReq.wdata;
        hiSeen_r       <= 1'b1;
      end
      if (wrHamMid)
      begin
        hamIn_r[15:8] <= regReq.wdata;
        midSeen_r     <= 1'b1;
      end
      if (wrHamLo)
      begin
        hamIn_r[7:0] <= regReq.wdata;
        hiSeen_r     <= 1'b0;
        midSeen_r    <= 1'b0;
      end
    end
  end

  // Decode from the low byte being written, so the result is ready next cycle
  assign decIn = wrHamLo ? {hamIn_r[23:8], regReq.wdata} : hamIn_r;

  hamming_decoder u_dec (
    .codeWord (decIn),
    .result24 (dec24),
    .result8  (dec8)
  );

  // Width chosen by whether high and mid were written since the last low
  // Low alone means 8/4
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      hamRes_r  <= 24'h000000;
      hamWide_r <= 1'b0;
    end
    else if (clkEn && wrHamLo)
    begin
      hamWide_r <= hiSeen_r && midSeen_r;
      if (hiSeen_r && midSeen_r)
        hamRes_r <= dec24;
      else
        hamRes_r <= {16'h0000, dec8};
    end
  end

  // Read data stands one cycle only, zero otherwise
  // Unmapped offsets read zero
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      regRdata_r <= 8'h00;
    else if (clkEn)
    begin
      regRdata_r <= 8'h00;
      if (regReq.rd)
      begin
        case (regReq.addr)
          OFF_ADDR_LOW:  regRdata_r <= addrPtr_r[7:0];
          OFF_ADDR_HIGH: regRdata_r <= {2'h0, addrPtr_r[ADDR_W-1:8]};
          OFF_HAM_LOW:   regRdata_r <= hamRes_r[7:0];
          OFF_HAM_MID:   regRdata_r <= hamRes_r[15:8];
          OFF_HAM_HIGH:  regRdata_r <= hamRes_r[23:16];
          OFF_STATUS:
          begin
            regRdata_r                 <= 8'h00;
            regRdata_r[ST_COUNT_LSB+:2] <= fifoCount;
            regRdata_r[ST_OVERRUN]     <= overrun_r;
            regRdata_r[ST_LINE_LSB+:2] <= lineState_r;
            regRdata_r[ST_HAM_WIDE]    <= hamWide_r;
          end
          default:       regRdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign regRdata = regRdata_r;

  // RAM side; write-allowed is a handshake, address from the pointer flop
  // Data is the head entry, meaningful only while write-allowed is high
  assign ramReq.writeAllowed = !fifoEmpty;
  assign ramReq.addr         = addrPtr_r;
  assign ramReq.data         = fifoMem_r[rdPtr_r[1:0]];

endmodule

`default_nettype wire

// [verif/teletext_acq_store_asserts.sv]
// Port assertions for the acquisition store
// Assumes a bind from the bench top; one clock domain.
`default_nettype none
module teletext_acq_store_asserts
  import teletext_acq_pkg::*;
(
  input wire logic                        clk_sys,
  input wire logic                        sys_rst,
  input wire logic                        clkEn,
  input wire teletext_acq_pkg::regReq_t   regReq,
  input wire logic [7:0]                  regRdata,
  input wire teletext_acq_pkg::filtByte_t filtIn,
  input wire logic                        framingOk,
  input wire logic                        lineSync,
  input wire logic                        vbiActive,
  input wire logic                        ramSlot,
  input wire teletext_acq_pkg::ramReq_t   ramReq
);
  import teletext_acq_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_rst;
    disable iff (1'b0) sys_rst && clkEn |=> !ramReq.writeAllowed && ramReq.addr == ADDR_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_hi;
    clkEn && regReq.wr && regReq.addr == OFF_ADDR_HIGH && !lineSync |=> ramReq.addr[13:8] == $past(regReq.wdata[5:0]);
  endproperty
  a_hi: assert property (p_hi) else $error("high address load wrong");
  property p_lo;
    clkEn && regReq.wr && regReq.addr == OFF_ADDR_LOW && !lineSync |=> ramReq.addr[7:0] == $past(regReq.wdata);
  endproperty
  a_lo: assert property (p_lo) else $error("low address load wrong");
  property p_pop;
    clkEn && ramSlot && ramReq.writeAllowed && !regReq.wr && !lineSync |=> ramReq.addr == $past(ramReq.addr) + 14'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("no post increment");
  property p_hold;
    clkEn && !ramSlot && !regReq.wr && !lineSync |=> $stable(ramReq.addr);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved without store");
  property p_nowr;
    clkEn && ramSlot && !ramReq.writeAllowed && !regReq.wr && !lineSync |=> $stable(ramReq.addr);
  endproperty
  a_nowr: assert property (p_nowr) else $error("empty slot moved address");
  property p_empty;
    !ramReq.writeAllowed && !filtIn.valid |=> !ramReq.writeAllowed;
  endproperty
  a_empty: assert property (p_empty) else $error("write allowed from nothing");
  property p_keep;
    clkEn && ramReq.writeAllowed && !ramSlot && !lineSync |=> ramReq.writeAllowed;
  endproperty
  a_keep: assert property (p_keep) else $error("write allowed lost");
  property p_rd;
    clkEn && !regReq.rd |=> regRdata == 8'h00;
  endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  c_pop: cover property (ramSlot && ramReq.writeAllowed);
  c_abort: cover property (lineSync && ramReq.writeAllowed);
  c_wide: cover property (regReq.rd && regReq.addr == OFF_HAM_HIGH);
endmodule
`default_nettype wire

// [verif/ram_side_model.sv]
// Display RAM side: slot generator and byte store
// Assumes the store's ramReq on the same clock.
`default_nettype none
module ram_side_model
  import teletext_acq_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire logic                      stall,
  input  wire logic                      slow,
  input  wire teletext_acq_pkg::ramReq_t ramReq,
  output logic                           ramSlot
);
  import teletext_acq_pkg::*;
  logic [7:0] mem [0:16383];
  logic [1:0] phase_r;
  // Slow mode leaves bytes waiting, stall fills the buffer
  always_ff @(posedge clk_sys)
  begin
    phase_r <= sys_rst ? 2'h0 : phase_r + 2'h1;
    ramSlot <= !sys_rst && !stall && (!slow || phase_r == 2'h0);
    if (ramSlot && ramReq.writeAllowed)
    begin
      mem[ramReq.addr] <= ramReq.data;
    end
  end
endmodule
`default_nettype wire

// [verif/teletext_acq_store_bench.sv]
// Self-checking bench for the acquisition store
// Assumes the package, the store, the RAM side model and the checker.
`default_nettype none
module teletext_acq_store_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import teletext_acq_pkg::*;
  typedef struct packed {logic wide; logic [17:0] data; logic [23:0] flip;} hamRow_t;
  logic       clk_sys   = 1'h0;
  logic       sys_rst   = 1'h1;
  logic       clkEn     = 1'h1;
  regReq_t    regReq    = '0;
  filtByte_t  filtIn    = '0;
  logic       framingOk = 1'h0;
  logic       lineSync  = 1'h0;
  logic       vbiActive = 1'h0;
  logic       stall     = 1'h1;
  logic       slow      = 1'h0;
  logic [7:0] regRdata;
  logic       ramSlot;
  ramReq_t    ramReq;
  logic [7:0] b0, b1, b2;
  logic [23:0] wordV, expV, gotV;
  logic       err;
  int         errCount  = 0;
  int         checks    = 0;
  int         cyc       = 0;
  hamRow_t    rows [10] = '{'{1'h1, 18'h2a5c3, 24'h0}, '{1'h1, 18'h3ffff, 24'h400000},
    '{1'h1, 18'h00001, 24'h800000}, '{1'h1, 18'h15555, 24'h000001}, '{1'h1, 18'h0f0f0, 24'h001020},
    '{1'h1, 18'h12345, 24'h008081}, '{1'h0, 18'ha, 24'h0}, '{1'h0, 18'h5, 24'h80},
    '{1'h0, 18'h3, 24'h40}, '{1'h0, 18'hc, 24'h06}};
  teletext_acq_store u_teletext_acq_store (.clk_sys, .sys_rst, .clkEn, .regReq, .regRdata, .filtIn,
    .framingOk, .lineSync, .vbiActive, .ramSlot, .ramReq);
  ram_side_model u_ram_side_model (.clk_sys, .sys_rst, .stall, .slow, .ramReq, .ramSlot);
  always #4 clk_sys = ~clk_sys;
  task automatic end_sim;
    if (errCount == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] a, input logic [23:0] b);
    checks++;
    if (a !== b)
    begin
      errCount++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, a, b);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regReq <= '{1'h1, 1'h0, a, d};
    @(posedge clk_sys);
    regReq.wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regReq <= '{1'h0, 1'h1, a, 8'h00};
    @(posedge clk_sys);
    regReq.rd <= 1'h0;
    #1 d = regRdata;
  endtask
  task automatic byteIn(input logic [7:0] d);
    @(posedge clk_sys);
    filtIn <= '{1'h1, d};
    @(posedge clk_sys);
    filtIn.valid <= 1'h0;
  endtask
  task automatic ctl(input logic f, input logic l, input logic s);
    @(posedge clk_sys);
    framingOk <= f;
    lineSync <= l;
    vbiActive <= 1'h1;
    stall <= s;
    @(posedge clk_sys);
    framingOk <= 1'h0;
    lineSync <= 1'h0;
    #1;
  endtask
  task automatic drain;
    #1;
    for (int i = 0; i < 100 && ramReq.writeAllowed !== 1'h0; i++)
      @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [23:0] enc24(input logic [17:0] d);
    logic [23:0] w;
    w = {1'h0, d[17:11], 1'h0, d[10:4], 1'h0, d[3:1], 1'h0, d[0], 2'h0};
    for (int i = 0; i < 5; i++)
      if (^(w & CHK24_MASK[i]) == 1'h0) w[(1 << i) - 1] = 1'h1;
    w[23] = ~^w[22:0];
    return w;
  endfunction
  function automatic logic [7:0] enc8(input logic [3:0] d);
    logic [7:0] w;
    w = {d[3], 1'h0, d[2], 1'h0, d[1], 1'h0, d[0], 1'h0};
    for (int i = 0; i < 4; i++)
      if (^(w & CHK8_MASK[i]) == 1'h0) w[2 * i] = 1'h1;
    return w;
  endfunction
  // Bounded run; a hang counts as a mismatch
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errCount++;
      end_sim();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    #1 chk({ramReq.writeAllowed, ramReq.addr}, 15'h0);
    rd(OFF_STATUS, b0);
    chk(b0, 8'h00);
    rd(4'hf, b0);
    chk(b0, 8'h00);
    foreach (rows[i])
    begin
      err = $countones(rows[i].flip) > 1;
      if (rows[i].wide)
      begin
        wordV = enc24(rows[i].data) ^ rows[i].flip;
        wr(OFF_HAM_HIGH, wordV[23:16]);
        wr(OFF_HAM_MID, wordV[15:8]);
        wr(OFF_HAM_LOW, wordV[7:0]);
        rd(OFF_HAM_LOW, b0);
        rd(OFF_HAM_MID, b1);
        rd(OFF_HAM_HIGH, b2);
        expV = err ? 24'h800000 : {6'h00, rows[i].data};
        gotV = err ? {b2[7], 23'h0} : {b2, b1, b0};
        chk(gotV, expV);
      end
      else
      begin
        wordV = enc8(rows[i].data[3:0]) ^ rows[i].flip;
        wr(OFF_HAM_LOW, wordV[7:0]);
        rd(OFF_HAM_LOW, b0);
        expV = err ? 24'h10 : {20'h0, rows[i].data[3:0]};
        gotV = err ? {19'h0, b0[4], 4'h0} : {16'h0, b0};
        chk(gotV, expV);
      end
    end
    wr(OFF_ADDR_HIGH, 8'h2f);
    wr(OFF_ADDR_LOW, 8'hf0);
    #1 chk(ramReq.addr, 14'h2ff0);
    ctl(1'h1, 1'h0, 1'h0);
    for (int i = 0; i < 44; i++)
      byteIn(i[7:0] ^ 8'h5a);
    drain();
    chk(ramReq.addr, 14'h3019);
    for (int i = 0; i < 41; i++)
      chk(u_ram_side_model.mem[14'h2ff0 + i], i[7:0] ^ 8'h5a);
    byteIn(8'h77);
    drain();
    chk(ramReq.addr, 14'h3019);
    ctl(1'h0, 1'h1, 1'h0);
    chk(ramReq.addr, 14'h3019);
    ctl(1'h1, 1'h0, 1'h1);
    for (int i = 0; i < 5; i++)
      byteIn(8'h30 + i[7:0]);
    rd(OFF_STATUS, b0);
    chk(b0[4:0], 5'h0f);
    @(posedge clk_sys);
    slow <= 1'h1;
    stall <= 1'h0;
    drain();
    chk(ramReq.addr, 14'h301c);
    ctl(1'h0, 1'h0, 1'h1);
    byteIn(8'h11);
    #1 chk(ramReq.writeAllowed, 1'h1);
    ctl(1'h0, 1'h1, 1'h1);
    chk({ramReq.writeAllowed, ramReq.addr}, {1'h0, 14'h3019});
    // Clock enable low freezes the pointer against a software write
    @(posedge clk_sys);
    clkEn <= 1'h0;
    wr(OFF_ADDR_LOW, 8'h55);
    chk(ramReq.addr, 14'h3019);
    clkEn <= 1'h1;
    end_sim();
  end
endmodule
bind teletext_acq_store teletext_acq_store_asserts u_teletext_acq_store_asserts (.clk_sys, .sys_rst, .clkEn,
  .regReq, .regRdata, .filtIn, .framingOk, .lineSync, .vbiActive, .ramSlot, .ramReq);
`default_nettype wire
